// >>> hdl/cach_ctrl.sv
// command/ack counter handshake, device side, with ahb-lite registers
// assumes one ahb-lite master on mclk and an executor on mclk
//
// What this block does
// - each telegram steps state, waits next
// - two-bit counters step by plus one
// - counters shown in the cyclic word to master
// - separate command and ack counters
// - both counters packed in one byte
// - start-up sets ack 0, command 1
// - start-up on reset or restart bit
// - cancel leaves command counter untouched
// - one error ack per cancelled chain
// - ack step and cancel withdrawal together
// - bit 6 marks a chained command
// - chain bit copied into acknowledgement
// - repetition steered by cyclic word bits
// - telegrams start only after counter change
// - command zero resets, ends active command
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cach_ctrl
  import cach_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // command executor
  output logic             exec_cmd_valid,
  input  wire logic        exec_cmd_ready,
  output logic [7:0]       exec_cmd_code,
  output logic             exec_abort,
  input  wire logic        exec_result_valid,
  input  wire logic [7:0]  exec_result_status,
  // tag presence pin
  input  wire logic        tag_present_pin
);

  // executor sequence states
  typedef enum logic [4:0] {
    CACH_ST_IDLE  = 5'h01,  // waiting for work
    CACH_ST_FETCH = 5'h02,  // buffer read in flight
    CACH_ST_ISSUE = 5'h04,  // offering command
    CACH_ST_BUSY  = 5'h08,  // command running
    CACH_ST_POST  = 5'h10   // waiting for free ack slot
  } cach_state_type;

  // register file
  logic [2:0]     cyc_out;        // master's cyclic bits
  logic [2:0]     cyc_out_q;      // previous cyclic bits
  logic [1:0]     cmd_counter;    // command state counter
  logic [1:0]     ack_counter;    // ack state counter
  logic           cmd_granted;    // counter stepped, command expected
  logic           ack_full;       // ack waiting to be fetched
  logic [15:0]    ack_word;       // status and code of pending ack
  logic           cancel_active;  // cancel seen, error ack not yet out
  // executor state
  cach_state_type state;          // current state
  cach_state_type next_state;     // next state
  logic [7:0]     cur_code;       // command in progress
  logic [7:0]     cur_status;     // its result status
  logic [7:0]     last_code;      // last command for repetition
  logic           have_last;      // last_code holds a command
  // buffer pointers
  logic [1:0]     wr_ptr;         // next free slot
  logic [1:0]     rd_ptr;         // oldest command
  logic [2:0]     buf_cnt;        // commands stored
  // bus tracking
  logic           dp_wr;          // write data phase pending
  logic [7:0]     dp_addr;        // its byte offset
  // tag pin synchroniser
  logic           tag_meta;       // first stage
  logic           tag_present_flag;  // second stage

  // buffer bundle
  cach_buf_if buf_bus ();

  // command store
  cach_cmd_buf u_buf (
    .mclk (mclk),
    .bus  (buf_bus)
  );

  // decode helper for word offsets
  function automatic logic ofs_hit(input logic [7:0] a, input logic [7:0] o);
    ofs_hit = (a[7:2] == o[7:2]);
  endfunction : ofs_hit

  // address phase decode
  wire ap_take = hsel & hready & htrans[1];  // valid transfer
  wire ap_rd   = ap_take & ~hwrite;          // read transfer
  wire [7:0] ap_addr = haddr[7:0];           // offset within block
  wire ap_in_range = (haddr[31:8] == 24'h000000);  // block window

  // data phase write strobes
  wire wr_go  = dp_wr & hready;                        // write completes
  wire wr_cyc = wr_go & ofs_hit(dp_addr, CACH_OFS_CYC_OUT);  // cyclic bits
  wire wr_cmd = wr_go & ofs_hit(dp_addr, CACH_OFS_CMD);  // command telegram

  // ack fetch by read of the ack register
  wire rd_ack = ap_rd & ap_in_range & ofs_hit(ap_addr, CACH_OFS_ACK);

  // command telegram accepted only when granted
  wire       cmd_ok   = wr_cmd & cmd_granted;
  wire [7:0] cmd_code = hwdata[7:0];           // incoming code
  wire       cmd_zero = cmd_ok & (cmd_code == CACH_CODE_RESET);
  wire       cmd_push = cmd_ok & ~cmd_zero;

  // edges of the master's cyclic bits
  wire restart_go = cyc_out[CACH_BIT_RESTART] & ~cyc_out_q[CACH_BIT_RESTART];
  wire cancel_go  = cyc_out[CACH_BIT_CANCEL] & ~cyc_out_q[CACH_BIT_CANCEL];
  wire abort_go   = (cancel_go | cmd_zero) & ~restart_go;  // cancel or reset command abort, not restart

  // repetition steered by the cyclic word
  wire repeat_active = cyc_out[CACH_BIT_REPEAT] & have_last;

  // buffer movement
  wire buf_pop   = (state == CACH_ST_FETCH);  // slot consumed
  wire buf_flush = abort_go | restart_go;     // drop queued commands

  // grant next command when a slot is free
  wire grant_go = ~cmd_granted & (buf_cnt < CACH_BUF_FULL) & ~buf_flush;

  // ack slot posting
  wire post_go = (state == CACH_ST_POST) & ~ack_full & ~restart_go;

  // cyclic input byte
  wire [7:0] cyc_in;  // status word to master
  assign cyc_in[CACH_POS_ACK_CNT +: 2] = ack_counter;
  assign cyc_in[CACH_POS_CMD_CNT +: 2] = cmd_counter;
  assign cyc_in[CACH_BIT_CANCEL_ACT]   = cancel_active;
  assign cyc_in[CACH_BIT_REPEAT_ACT]   = repeat_active;
  assign cyc_in[CACH_BIT_TAG]          = tag_present_flag;
  assign cyc_in[7]                     = 1'b0;

  // read data selection
  wire [31:0] rd_mux =
    ~ap_in_range                         ? 32'h00000000 :
    ofs_hit(ap_addr, CACH_OFS_CYC_OUT)   ? {29'h0, cyc_out} :
    ofs_hit(ap_addr, CACH_OFS_CYC_IN)    ? {24'h0, cyc_in} :
    ofs_hit(ap_addr, CACH_OFS_ACK)       ? {16'h0, ack_word} :
                                           32'h00000000;

  // buffer bundle wiring
  assign buf_bus.wr_en   = cmd_push;
  assign buf_bus.wr_addr = wr_ptr;
  assign buf_bus.wr_data = cmd_code;
  assign buf_bus.rd_addr = rd_ptr;

  // bus answers: always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // executor handshake
  assign exec_cmd_valid = (state == CACH_ST_ISSUE);
  assign exec_cmd_code  = cur_code;

  // tag pin through two flops
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tag_meta         <= 1'b0;
      tag_present_flag <= 1'b0;
    end else begin
      tag_meta         <= tag_present_pin;
      tag_present_flag <= tag_meta;
    end
  end

  // bus address phase capture and read data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      if (hready) begin
        // new address phase or idle
        dp_wr   <= ap_take & hwrite & ap_in_range;
        dp_addr <= ap_addr;
      end
      if (ap_rd) begin
        // read data stands during the data phase
        hrdata <= rd_mux;
      end
    end
  end

  // cyclic output bits from the master
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_out   <= 3'h0;
      cyc_out_q <= 3'h0;
    end else begin
      cyc_out_q <= cyc_out;
      if (wr_cyc) begin
        cyc_out <= hwdata[2:0];
      end
    end
  end

  // command counter and grant
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_counter <= CACH_CMD_CNT_RST;
      cmd_granted <= 1'b1;
    end else if (restart_go) begin
      cmd_counter <= CACH_CMD_CNT_RST;
      cmd_granted <= 1'b1;
    end else if (cmd_ok) begin
      // grant used up by this telegram
      cmd_granted <= 1'b0;
    end else if (grant_go) begin
      // step and wrap, cancel leaves it alone
      cmd_counter <= cmd_counter + 2'h1;
      cmd_granted <= 1'b1;
    end
  end

  // ack counter, ack slot and cancel flag
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_counter   <= CACH_ACK_CNT_RST;
      ack_full      <= 1'b0;
      ack_word      <= 16'h0000;
      cancel_active <= 1'b0;
    end else if (restart_go) begin
      ack_counter   <= CACH_ACK_CNT_RST;
      ack_full      <= 1'b0;
      ack_word      <= 16'h0000;
      cancel_active <= 1'b0;
    end else begin
      if (post_go) begin
        // new ack, chain bit carried in the code
        ack_counter <= ack_counter + 2'h1;
        ack_full    <= 1'b1;
        ack_word    <= {cur_status, cur_code};
      end else if (rd_ack & ack_full) begin
        // fetched by the master
        ack_full <= 1'b0;
      end
      if (cancel_go) begin
        cancel_active <= 1'b1;
      end else if (post_go) begin
        // withdrawn with the error ack step
        cancel_active <= 1'b0;
      end
    end
  end

  // buffer pointers and fill level
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr  <= 2'h0;
      rd_ptr  <= 2'h0;
      buf_cnt <= 3'h0;
    end else if (buf_flush) begin
      // abort drops every queued command
      wr_ptr  <= 2'h0;
      rd_ptr  <= 2'h0;
      buf_cnt <= 3'h0;
    end else begin
      if (cmd_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (buf_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      // net fill change
      if (cmd_push & ~buf_pop) begin
        buf_cnt <= buf_cnt + 3'h1;
      end else if (buf_pop & ~cmd_push) begin
        buf_cnt <= buf_cnt - 3'h1;
      end
    end
  end

  // executor next state
  always_comb begin
    next_state = state;
    unique case (state)
      CACH_ST_IDLE: begin
        if (buf_cnt != 3'h0) begin
          next_state = CACH_ST_FETCH;
        end else if (repeat_active) begin
          // repeat the last command
          next_state = CACH_ST_ISSUE;
        end
      end
      CACH_ST_FETCH: begin
        next_state = CACH_ST_ISSUE;
      end
      CACH_ST_ISSUE: begin
        if (exec_cmd_ready) begin
          next_state = CACH_ST_BUSY;
        end
      end
      CACH_ST_BUSY: begin
        if (exec_result_valid) begin
          next_state = CACH_ST_POST;
        end
      end
      CACH_ST_POST: begin
        if (~ack_full) begin
          next_state = CACH_ST_IDLE;
        end
      end
      default: begin
        // illegal code recovers to idle
        next_state = CACH_ST_IDLE;
      end
    endcase
  end

  // executor state and command registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= CACH_ST_IDLE;
      cur_code   <= 8'h00;
      cur_status <= 8'h00;
      last_code  <= 8'h00;
      have_last  <= 1'b0;
      exec_abort <= 1'b0;
    end else begin
      exec_abort <= abort_go | restart_go;
      if (restart_go) begin
        // start-up: forget everything
        state     <= CACH_ST_IDLE;
        have_last <= 1'b0;
      end else if (abort_go) begin
        // one ack covers the whole aborted chain
        state      <= CACH_ST_POST;
        cur_code   <= cmd_zero ? CACH_CODE_RESET : cur_code;
        cur_status <= cmd_zero ? CACH_STAT_OK : CACH_STAT_CANCEL;
        have_last  <= 1'b0;
      end else begin
        state <= next_state;
        if (state == CACH_ST_FETCH) begin
          cur_code  <= buf_bus.rd_data;
          last_code <= buf_bus.rd_data;
          have_last <= 1'b1;
        end
        if ((state == CACH_ST_IDLE) & (buf_cnt == 3'h0) & repeat_active) begin
          cur_code <= last_code;
        end
        if ((state == CACH_ST_BUSY) & exec_result_valid) begin
          cur_status <= exec_result_status;
        end
      end
    end
  end

endmodule : cach_ctrl
`default_nettype wire

// >>> hdl/cach_pkg.sv
// constants shared by the command/ack counter handshake block
// assumes a single clock domain and a 32-bit register bus
`default_nettype none
package cach_pkg;
  // register byte offsets
  localparam logic [7:0] CACH_OFS_CYC_OUT = 8'h00;  // cyclic word from master
  localparam logic [7:0] CACH_OFS_CYC_IN  = 8'h04;  // cyclic word to master
  localparam logic [7:0] CACH_OFS_CMD     = 8'h08;  // command telegram
  localparam logic [7:0] CACH_OFS_ACK     = 8'h0c;  // acknowledgement telegram
  // cyclic output word bit positions
  localparam int CACH_BIT_RESTART = 0;  // restart request
  localparam int CACH_BIT_CANCEL  = 1;  // cancel request
  localparam int CACH_BIT_REPEAT  = 2;  // command repetition request
  // cyclic input word field positions
  localparam int CACH_POS_ACK_CNT = 0;  // ack counter, bits 1:0
  localparam int CACH_POS_CMD_CNT = 2;  // command counter, bits 3:2
  localparam int CACH_BIT_CANCEL_ACT = 4;  // cancel still active
  localparam int CACH_BIT_REPEAT_ACT = 5;  // repetition running
  localparam int CACH_BIT_TAG = 6;  // tag present
  // command code fields
  localparam int CACH_BIT_CHAIN = 6;  // chaining bit
  localparam logic [7:0] CACH_CODE_RESET = 8'h00;  // self reset command
  // counter reset values after start-up
  localparam logic [1:0] CACH_CMD_CNT_RST = 2'h1;
  localparam logic [1:0] CACH_ACK_CNT_RST = 2'h0;
  // ack status codes
  localparam logic [7:0] CACH_STAT_OK = 8'h00;
  localparam logic [7:0] CACH_STAT_CANCEL = 8'h1f;
  // command buffer geometry
  localparam int CACH_BUF_AW = 2;
  localparam int CACH_BUF_DEPTH = 4;
  localparam logic [2:0] CACH_BUF_FULL = 3'h4;
endpackage : cach_pkg
`default_nettype wire

// >>> hdl/cach_buf_if.sv
// bundle between the controller and its command buffer
// assumes both ends on the same clock
`timescale 1ns/10ps
`default_nettype none
interface cach_buf_if;
  logic       wr_en;    // write strobe
  logic [1:0] wr_addr;  // write slot
  logic [7:0] wr_data;  // command code in
  logic [1:0] rd_addr;  // read slot
  logic [7:0] rd_data;  // registered read data
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : cach_buf_if
`default_nettype wire

// >>> hdl/cach_cmd_buf.sv
// small command store with registered read data
// assumes addresses come from the controller on mclk
`timescale 1ns/10ps
`default_nettype none
module cach_cmd_buf
  import cach_pkg::*;
(
  // clock
  input wire logic mclk,
  // access bundle
  cach_buf_if.mem  bus
);
  logic [7:0] mem [CACH_BUF_DEPTH];  // command slots

  // write one slot
  always_ff @(posedge mclk) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
  end

  // read data always from a register
  always_ff @(posedge mclk) begin
    bus.rd_data <= mem[bus.rd_addr];
  end
endmodule : cach_cmd_buf
`default_nettype wire

// >>> bench/cach_ctrl_assertions.sv
// checker for the command/ack counter block, watching only its ports
// assumes one ahb-lite master on mclk and an executor behind the block
`timescale 1ns/10ps
`default_nettype none
module cach_ctrl_assertions
  import cach_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // ahb-lite side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // executor side
  input wire logic        exec_cmd_valid,
  input wire logic        exec_cmd_ready,
  input wire logic [7:0]  exec_cmd_code,
  input wire logic        exec_abort
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic       dp_wr;  // write data phase
  logic       dp_rd;  // read data phase
  logic [7:0] dp_a;   // offset of that phase
  logic [2:0] out_q;  // cyclic out word held
  wire        tk     = hsel && hready && htrans[1];  // address phase taken
  wire        cyc_wr = dp_wr && dp_a == CACH_OFS_CYC_OUT;  // cyclic out write
  wire        rst_up = cyc_wr && hwdata[CACH_BIT_RESTART] && !out_q[CACH_BIT_RESTART];  // restart rise
  wire        can_up = cyc_wr && hwdata[CACH_BIT_CANCEL] && !out_q[CACH_BIT_CANCEL];  // cancel rise
  // follow bus phases and the cyclic out word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_a  <= 8'h00;
      out_q <= 3'h0;
    end else begin
      dp_wr <= tk && hwrite;
      dp_rd <= tk && !hwrite;
      dp_a  <= haddr[7:0];
      if (cyc_wr) begin
        out_q <= hwdata[2:0];
      end
    end
  end
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready or not okay");
  property p_pulse; exec_abort |=> !exec_abort; endproperty
  a_pulse: assert property (p_pulse)
    else $error("abort held too long");
  property p_hold;
    exec_cmd_valid && !exec_cmd_ready |=> exec_abort || (exec_cmd_valid && $stable(exec_cmd_code));
  endproperty
  a_hold: assert property (p_hold)
    else $error("offered command dropped or changed");
  property p_one; exec_cmd_valid && exec_cmd_ready |=> !exec_cmd_valid; endproperty
  a_one: assert property (p_one)
    else $error("second command offered while busy");
  property p_idle; exec_abort |=> !exec_cmd_valid; endproperty
  a_idle: assert property (p_idle)
    else $error("command offered right after abort");
  property p_restart; rst_up |-> ##[1:4] exec_abort; endproperty
  a_restart: assert property (p_restart)
    else $error("restart without abort");
  property p_cancel; can_up |-> ##[1:4] exec_abort; endproperty
  a_cancel: assert property (p_cancel)
    else $error("cancel without abort");
  property p_fmt; dp_rd && dp_a == CACH_OFS_CYC_IN |-> hrdata[31:7] == 25'h0; endproperty
  a_fmt: assert property (p_fmt)
    else $error("cyclic in word has stray bits");
  c_restart: cover property (rst_up);
  c_cancel: cover property (can_up);
  c_chain: cover property (exec_cmd_valid && exec_cmd_ready && exec_cmd_code[CACH_BIT_CHAIN]);
endmodule : cach_ctrl_assertions
bind cach_ctrl cach_ctrl_assertions u_chk (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .exec_cmd_valid, .exec_cmd_ready, .exec_cmd_code, .exec_abort);
`default_nettype wire

// >>> bench/cach_exec_model.sv
// executor model standing behind the handshake block
// assumes the controller offers one command at a time on mclk
`timescale 1ns/10ps
`default_nettype none
module cach_exec_model
  import cach_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // controller side
  input  wire logic       exec_cmd_valid,
  output logic            exec_cmd_ready,
  input  wire logic       exec_abort,
  output logic            exec_result_valid,
  output logic [7:0]      exec_result_status,
  // run time in cycles
  input  wire logic [7:0] lat
);
  logic       busy;  // command running
  logic [7:0] left;  // cycles still to run
  // take, run and report one command
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy               <= 1'b0;
      left               <= 8'h00;
      exec_cmd_ready     <= 1'b0;
      exec_result_valid  <= 1'b0;
      exec_result_status <= 8'h5a;
    end else begin
      exec_cmd_ready     <= exec_cmd_valid && !busy && !exec_cmd_ready;
      exec_result_valid  <= 1'b0;
      exec_result_status <= ~exec_result_status;  // no stale status between results
      if (exec_abort) begin
        busy <= 1'b0;
      end else if (exec_cmd_valid && exec_cmd_ready) begin
        busy <= 1'b1;
        left <= lat;
      end else if (busy && left == 8'h00) begin
        busy               <= 1'b0;
        exec_result_valid  <= 1'b1;
        exec_result_status <= CACH_STAT_OK;
      end else if (busy) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule : cach_exec_model
`default_nettype wire

// >>> bench/tb_cach_ctrl.sv
// bench for the command/ack counter block: ahb-lite master tasks and scenarios
// assumes the executor model and the bound checker beside it
`timescale 1ns/10ps
`default_nettype none
module tb_cach_ctrl
  import cach_pkg::*;
;
  logic        mclk    = 1'b0;  // bench clock
  logic        sys_rst = 1'b1;  // reset at start
  logic        hsel    = 1'b0;  // bus request
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        tag_present_pin = 1'b0;
  logic [7:0]  lat     = 8'h03;  // executor run time
  logic        hreadyout, hresp, exec_cmd_valid, exec_cmd_ready, exec_abort, exec_result_valid;
  logic [31:0] hrdata;
  logic [7:0]  exec_cmd_code, exec_result_status;
  logic [1:0]  cc      = 2'h1;  // command count that opens the grant
  logic [1:0]  ac      = 2'h0;  // last ack count fetched
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  logic [7:0]  codes [5] = '{8'h01, 8'h42, 8'h03, 8'h4a, 8'h02};
  cach_ctrl uut (
    .mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .exec_cmd_valid, .exec_cmd_ready, .exec_cmd_code, .exec_abort, .exec_result_valid,
    .exec_result_status, .tag_present_pin
  );
  cach_exec_model exe (
    .mclk, .sys_rst, .exec_cmd_valid, .exec_cmd_ready, .exec_abort, .exec_result_valid, .exec_result_status, .lat
  );
  // clock
  always #4 mclk = ~mclk;
  // cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // single write: address phase, then data phase
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask : ahb_wr
  // single read, data taken at the closing edge
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahb_rd
  function automatic logic [7:0] cw(input logic [1:0] c, input logic [1:0] a);
    return {4'h0, c, a};
  endfunction : cw
  // watch the cyclic word until masked bits match
  task automatic poll(input string nm, input logic [7:0] m, input logic [7:0] v);
    logic [31:0] d;
    for (int i = 0; i < 400; i++) begin
      ahb_rd(CACH_OFS_CYC_IN, d);
      if ((d[7:0] & m) === v) break;
    end
    chk(nm, {24'h0, d[7:0] & m}, {24'h0, v});
  endtask : poll
  task automatic send(input logic [7:0] c);
    poll("grant", 8'h0c, cw(cc, 2'h0));
    ahb_wr(CACH_OFS_CMD, {24'h0, c});
    cc = cc + 2'h1;
  endtask : send
  task automatic fetch(input logic [15:0] e);
    logic [31:0] d;
    ac = ac + 2'h1;
    poll("ack count", 8'h03, cw(2'h0, ac));
    ahb_rd(CACH_OFS_ACK, d);
    chk("ack word", d, {16'h0, e});
  endtask : fetch
  initial begin
    logic [31:0] d;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    ahb_rd(CACH_OFS_CYC_IN, d);
    chk("start word", d, {24'h0, cw(2'h1, 2'h0)});
    tag_present_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    ahb_rd(CACH_OFS_CYC_IN, d);
    chk("tag word", d, 32'h44);
    tag_present_pin <= 1'b0;
    ahb_wr(8'h10, 32'hffff_ffff);
    ahb_rd(8'h10, d);
    chk("unmapped", d, 32'h0);
    // one at a time, counters wrap
    foreach (codes[i]) begin
      send(codes[i]);
      fetch({CACH_STAT_OK, codes[i]});
    end
    // chained, buffer filled until grant stays shut
    lat <= 8'h50;
    foreach (codes[i]) send(codes[i] | 8'h40);
    repeat (8) @(posedge mclk);
    ahb_rd(CACH_OFS_CYC_IN, d);
    chk("full grant", {30'h0, d[3:2]}, {30'h0, cc - 2'h1});
    foreach (codes[i]) fetch({CACH_STAT_OK, codes[i] | 8'h40});
    // cancel of a chain
    lat <= 8'hc8;
    send(8'h41);
    send(8'h42);
    poll("grant", 8'h0c, cw(cc, 2'h0));
    ahb_wr(CACH_OFS_CYC_OUT, 32'h2);
    // ack step must arrive with the cancel flag already dropped
    poll("cancel drop", 8'h13, cw(2'h0, ac + 2'h1));
    fetch({CACH_STAT_CANCEL, 8'h41});
    ahb_wr(CACH_OFS_CYC_OUT, 32'h0);
    repeat (300) @(posedge mclk);
    ahb_rd(CACH_OFS_CYC_IN, d);
    chk("after cancel", d, {24'h0, cw(cc, ac)});
    // reset command ends the running one
    send(8'h02);
    repeat (10) @(posedge mclk);
    send(CACH_CODE_RESET);
    fetch({CACH_STAT_OK, 8'h00});
    repeat (300) @(posedge mclk);
    poll("no result", 8'h03, cw(2'h0, ac));
    // repetition from the cyclic word
    lat <= 8'h05;
    send(8'h03);
    fetch({CACH_STAT_OK, 8'h03});
    ahb_wr(CACH_OFS_CYC_OUT, 32'h4);
    poll("repeat flag", 8'h20, 8'h20);
    fetch({CACH_STAT_OK, 8'h03});
    fetch({CACH_STAT_OK, 8'h03});
    ahb_wr(CACH_OFS_CYC_OUT, 32'h0);
    // restart resynchronises both counters
    ahb_wr(CACH_OFS_CYC_OUT, 32'h1);
    poll("restart", 8'h0f, cw(2'h1, 2'h0));
    ahb_wr(CACH_OFS_CYC_OUT, 32'h0);
    cc = 2'h1;
    ac = 2'h0;
    send(8'h0a);
    fetch({CACH_STAT_OK, 8'h0a});
    test_done();
  end
endmodule : tb_cach_ctrl
`default_nettype wire
